// File: hdl/fpdm_image_mux.sv
// Purpose: picks one byte of an input image
// Assumes: slot 0 is the communicator, slots 1..NUM_MOD modules
// Notes:   floats are sent most significant byte first
`timescale 1ns/100ps
`default_nettype none
module fpdm_image_mux #(
  parameter int NUM_MOD = 8
) (
  input  wire logic [3:0]  slot,
  input  wire logic [2:0]  idx,
  input  wire logic        trigger,
  input  wire logic [31:0] stationTemp,
  input  wire logic [31:0] objTemp,
  input  wire logic [31:0] intTemp,
  output logic      [7:0]  byteData,
  output logic      [3:0]  imgLen
);
  function automatic logic [7:0] beByte(input logic [31:0] w, input logic [1:0] n);
    beByte = w[31 - 8 * n -: 8];
  endfunction

  always_comb begin
    byteData = 8'h00;
    imgLen   = 4'h0;
    if (slot == 4'h0) begin
      imgLen = fpdm_pkg::COMM_IMG_LEN;
      if (idx == 3'h0) begin
        byteData = {7'h00, trigger};
      end else if (idx <= 3'h4) begin
        byteData = beByte(stationTemp, 2'(idx - fpdm_pkg::COMM_TEMP_IDX));
      end
    end else if (int'(slot) <= NUM_MOD) begin
      imgLen   = fpdm_pkg::MOD_IMG_LEN;
      byteData = idx[2] ? beByte(intTemp, idx[1:0]) : beByte(objTemp, idx[1:0]);
    end
  end
endmodule
`default_nettype wire

// File: hdl/fpdm_param_check.sv
// Purpose: splits a 3-byte output image and judges it
// Assumes: byte 0 in bits 23:16, value high byte in 15:8
// Notes:   purely combinational
`timescale 1ns/100ps
`default_nettype none
module fpdm_param_check #(
  parameter int NUM_MOD = 8
) (
  input  wire logic [3:0]  imgSlot,
  input  wire logic [23:0] imgData,
  output logic      [7:0]  typeCode,
  output logic      [15:0] value,
  output logic             isIgnore,
  output logic             accept
);
  logic slotOk;

  assign typeCode = imgData[23:16];
  assign value    = imgData[15:0];
  assign slotOk   = (imgSlot != 4'h0) && (int'(imgSlot) <= NUM_MOD);
  assign isIgnore = (typeCode == fpdm_pkg::PT_IGNORE);
  // out-of-range types and values fall out of paramOk
  assign accept   = slotOk && !isIgnore && fpdm_pkg::paramOk(typeCode, value);
endmodule
`default_nettype wire

// File: hdl/fpdm_pkg.sv
// Purpose: shared constants for the fieldbus process data mapper
// Assumes: 32-bit register words, byte addressed
// Notes:   parameter value ranges live here as one checking function
package fpdm_pkg;

  // ----------------------------------------------------------------
  // image layout
  // ----------------------------------------------------------------
  localparam logic [3:0] COMM_IMG_LEN = 4'h5;
  localparam logic [3:0] MOD_IMG_LEN  = 4'h8;
  localparam logic [2:0] COMM_TEMP_IDX = 3'h1;
  localparam logic [2:0] MOD_OBJ_IDX   = 3'h0;
  localparam logic [2:0] MOD_INT_IDX   = 3'h4;
  localparam logic [7:0] IOPS_GOOD    = 8'h80;
  localparam logic [7:0] IOPS_BAD     = 8'h00;
  localparam int         COMM_DIAG_BIT = 2;
  localparam int         MOD_DIAG_BIT  = 6;

  // ----------------------------------------------------------------
  // parameter type codes of the output image
  // ----------------------------------------------------------------
  localparam logic [7:0] PT_IGNORE = 8'h00;
  localparam logic [7:0] PT_EMIS   = 8'h01;
  localparam logic [7:0] PT_LASER  = 8'h02;
  localparam logic [7:0] PT_BKG    = 8'h03;
  localparam logic [7:0] PT_AVG    = 8'h04;
  localparam logic [7:0] PT_PEAK   = 8'h05;
  localparam logic [7:0] PT_VALLEY = 8'h06;
  localparam logic [7:0] PT_SETPT  = 8'h07;

  // ----------------------------------------------------------------
  // ranges (emissivity and transmissivity times 1000, times 0.1 s)
  // ----------------------------------------------------------------
  localparam logic [15:0] EMIS_MIN  = 16'h0064;
  localparam logic [15:0] EMIS_MAX  = 16'h044c;
  localparam logic [15:0] TRANS_MAX = 16'h03e8;
  localparam logic [15:0] TIME_MAX  = 16'h2706;
  localparam logic [15:0] SEL_MAX   = 16'h0002;

  // ----------------------------------------------------------------
  // register map (word indices; MOD_BASE_BLK is a 64-byte block index)
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_CTRL    = 3'h0;
  localparam logic [2:0] REG_STATEMP = 3'h1;
  localparam logic [2:0] REG_DIAGEN  = 3'h2;
  localparam logic [2:0] REG_VALID   = 3'h3;
  localparam logic [2:0] REG_COMMFLT = 3'h4;
  localparam logic [2:0] REG_CFGFLT  = 3'h5;
  localparam logic [2:0] REG_REJECT  = 3'h6;
  localparam logic [2:0] REG_STATUS  = 3'h7;
  localparam logic [3:0] MOD_BASE_BLK = 4'h4;
  localparam logic [3:0] MREG_OBJ    = 4'h0;
  localparam logic [3:0] MREG_INT    = 4'h1;
  localparam logic [3:0] MREG_TRANS  = 4'h9;
  localparam logic [3:0] MREG_MODES  = 4'ha;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] EMIS_RST  = 16'h03e8;
  localparam logic [15:0] TRANS_RST = 16'h03e8;
  localparam logic [15:0] PARAM_RST = 16'h0000;
  localparam logic [31:0] WORD_RST  = 32'h0000_0000;

  typedef enum logic {BUS_IDLE = 1'b0, BUS_ACK = 1'b1} fpdm_bus_state_type;

  // value accepted for a parameter type, same scaling on bus and image
  function automatic logic paramOk(input logic [7:0] t, input logic [15:0] v);
    case (t)
      PT_EMIS:                    paramOk = (v >= EMIS_MIN) && (v <= EMIS_MAX);
      PT_LASER:                   paramOk = (v <= SEL_MAX);
      PT_AVG, PT_PEAK, PT_VALLEY: paramOk = (v <= TIME_MAX);
      PT_BKG, PT_SETPT:           paramOk = 1'b1;
      default:                    paramOk = 1'b0;
    endcase
  endfunction

endpackage

// File: hdl/fpdm_top.sv
// Purpose: maps communicator and pyrometer modules onto cyclic images
// Assumes: firmware fills temperatures and faults over Avalon-MM
// Notes:   one wait cycle on every bus access
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module fpdm_top #(
  parameter int NUM_MOD = 8
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        triggerIn,
  input  wire logic        inRdReq,
  input  wire logic [3:0]  inRdSlot,
  input  wire logic [2:0]  inRdIdx,
  output logic             inRdValid,
  output logic      [7:0]  inRdData,
  output logic      [3:0]  inRdLen,
  output logic      [7:0]  inRdIops,
  input  wire logic        outImgValid,
  input  wire logic [3:0]  outImgSlot,
  input  wire logic [23:0] outImgData,
  output logic             paramUpdValid,
  output logic      [3:0]  paramUpdSlot,
  output logic      [7:0]  paramUpdType,
  output logic      [15:0] paramUpdValue,
  output logic      [NUM_MOD:0] chanDiag,
  output logic      [7:0]  commDiag,
  output logic             diagIrq,
  output logic             stationProblem
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fpdm_pkg::fpdm_bus_state_type busState_reg;
  logic [31:0]  statTemp_reg;
  logic         run_reg;
  logic [NUM_MOD:0]   diagEn_reg;
  logic [NUM_MOD:0]   cfgFault_reg;
  logic [NUM_MOD-1:0] valid_reg;
  logic [NUM_MOD-1:0] commFault_reg;
  logic [NUM_MOD-1:0] reject_reg;
  logic [31:0]  objTemp_reg  [NUM_MOD];
  logic [31:0]  intTemp_reg  [NUM_MOD];
  logic [15:0]  param_reg    [NUM_MOD][1:7];
  logic [15:0]  trans_reg    [NUM_MOD];
  logic [1:0]   ambMode_reg  [NUM_MOD];
  logic [1:0]   relayMode_reg[NUM_MOD];
  logic [31:0]  rdMux;
  logic [31:0]  wrWord;
  logic         isGlobal;
  logic [3:0]   modBlk;
  int           wrMod;
  logic [3:0]   mReg;
  logic         busWr;
  int           rdMod;
  int           imgMod;
  logic [7:0]   imgType;
  logic [15:0]  imgValue;
  logic         imgIgnore;
  logic         imgAccept;
  logic         imgTake;
  logic [7:0]   muxByte;
  logic [3:0]   muxLen;

  // ----------------------------------------------------------------
  // bus slave: request seen, then one cycle with waitrequest low
  // ----------------------------------------------------------------
  // only the first eight words are global; the rest of that block reads zero
  assign isGlobal = (avs_address[9:5] == 5'h00);
  assign modBlk   = avs_address[9:6] - fpdm_pkg::MOD_BASE_BLK;
  assign wrMod    = int'(modBlk);
  assign mReg     = avs_address[5:2];
  // a write lands at the edge where the master sees waitrequest low
  assign busWr    = (busState_reg == fpdm_pkg::BUS_ACK) && avs_write;

  function automatic logic [31:0] beMerge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      beMerge[8*i +: 8] = be[i] ? n[8*i +: 8] : o[8*i +: 8];
    end
  endfunction

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busState_reg    <= fpdm_pkg::BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= fpdm_pkg::WORD_RST;
    end else begin
      case (busState_reg)
        fpdm_pkg::BUS_IDLE: begin
          if (avs_read || avs_write) begin
            busState_reg    <= fpdm_pkg::BUS_ACK;
            avs_waitrequest <= 1'b0;
            avs_readdata    <= avs_read ? rdMux : fpdm_pkg::WORD_RST;
          end
        end
        fpdm_pkg::BUS_ACK: begin
          busState_reg    <= fpdm_pkg::BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          busState_reg    <= fpdm_pkg::BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // unmapped addresses read zero and ignore writes
  always_comb begin
    rdMux = fpdm_pkg::WORD_RST;
    rdMod = int'(modBlk);
    if (isGlobal) begin
      case (avs_address[4:2])
        fpdm_pkg::REG_CTRL:    rdMux = {31'h0, run_reg};
        fpdm_pkg::REG_STATEMP: rdMux = statTemp_reg;
        fpdm_pkg::REG_DIAGEN:  rdMux = 32'(diagEn_reg);
        fpdm_pkg::REG_VALID:   rdMux = 32'(valid_reg);
        fpdm_pkg::REG_COMMFLT: rdMux = 32'(commFault_reg);
        fpdm_pkg::REG_CFGFLT:  rdMux = 32'(cfgFault_reg);
        fpdm_pkg::REG_REJECT:  rdMux = 32'(reject_reg);
        fpdm_pkg::REG_STATUS:  rdMux = {16'h0, commDiag, 6'h0, triggerIn, stationProblem};
        default:               rdMux = fpdm_pkg::WORD_RST;
      endcase
    end else if (rdMod < NUM_MOD) begin
      case (mReg)
        fpdm_pkg::MREG_OBJ:   rdMux = objTemp_reg[rdMod];
        fpdm_pkg::MREG_INT:   rdMux = intTemp_reg[rdMod];
        fpdm_pkg::MREG_TRANS: rdMux = {16'h0, trans_reg[rdMod]};
        fpdm_pkg::MREG_MODES: rdMux = {28'h0, relayMode_reg[rdMod], ambMode_reg[rdMod]};
        default: begin
          if (mReg >= 4'h2 && mReg <= 4'h8) begin
            rdMux = {16'h0, param_reg[rdMod][int'(mReg) - 1]};
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // global registers
  // ----------------------------------------------------------------
  assign wrWord = avs_writedata;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      run_reg       <= 1'b0;
      statTemp_reg  <= fpdm_pkg::WORD_RST;
      diagEn_reg    <= '0;
      valid_reg     <= '0;
      commFault_reg <= '0;
      cfgFault_reg  <= '0;
    end else if (busWr && isGlobal) begin
      case (avs_address[4:2])
        fpdm_pkg::REG_CTRL:    run_reg       <= avs_byteenable[0] ? wrWord[0] : run_reg;
        fpdm_pkg::REG_STATEMP: statTemp_reg  <= beMerge(statTemp_reg, wrWord, avs_byteenable);
        fpdm_pkg::REG_DIAGEN:  diagEn_reg    <= (NUM_MOD+1)'(beMerge(32'(diagEn_reg), wrWord, avs_byteenable));
        fpdm_pkg::REG_VALID:   valid_reg     <= NUM_MOD'(beMerge(32'(valid_reg), wrWord, avs_byteenable));
        fpdm_pkg::REG_COMMFLT: commFault_reg <= NUM_MOD'(beMerge(32'(commFault_reg), wrWord, avs_byteenable));
        fpdm_pkg::REG_CFGFLT:  cfgFault_reg  <= (NUM_MOD+1)'(beMerge(32'(cfgFault_reg), wrWord, avs_byteenable));
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // output image: judged, then overrides the start-up setting
  // ----------------------------------------------------------------
  fpdm_param_check #(
    .NUM_MOD (NUM_MOD)
  ) u_check (
    .imgSlot  (outImgSlot),
    .imgData  (outImgData),
    .typeCode (imgType),
    .value    (imgValue),
    .isIgnore (imgIgnore),
    .accept   (imgAccept)
  );

  assign imgMod  = int'(outImgSlot) - 1;
  assign imgTake = outImgValid && run_reg && imgAccept;

  // image wins over a bus write in the same cycle, being the later setting
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int m = 0; m < NUM_MOD; m++) begin
        objTemp_reg[m]   <= fpdm_pkg::WORD_RST;
        intTemp_reg[m]   <= fpdm_pkg::WORD_RST;
        trans_reg[m]     <= fpdm_pkg::TRANS_RST;
        ambMode_reg[m]   <= 2'h0;
        relayMode_reg[m] <= 2'h0;
        for (int t = 1; t <= 7; t++) begin
          param_reg[m][t] <= (t == 1) ? fpdm_pkg::EMIS_RST : fpdm_pkg::PARAM_RST;
        end
      end
    end else begin
      if (busWr && !isGlobal && wrMod < NUM_MOD) begin
        case (mReg)
          fpdm_pkg::MREG_OBJ: objTemp_reg[wrMod] <= beMerge(objTemp_reg[wrMod], wrWord, avs_byteenable);
          fpdm_pkg::MREG_INT: intTemp_reg[wrMod] <= beMerge(intTemp_reg[wrMod], wrWord, avs_byteenable);
          fpdm_pkg::MREG_TRANS: begin
            if (wrWord[15:0] >= fpdm_pkg::EMIS_MIN && wrWord[15:0] <= fpdm_pkg::TRANS_MAX) begin
              trans_reg[wrMod] <= wrWord[15:0];
            end
          end
          fpdm_pkg::MREG_MODES: begin
            if (wrWord[1:0] != 2'h3) begin
              ambMode_reg[wrMod] <= wrWord[1:0];
            end
            if (wrWord[3:2] != 2'h3) begin
              relayMode_reg[wrMod] <= wrWord[3:2];
            end
          end
          default: begin
            // start-up configuration takes the same scaled ranges
            if (mReg >= 4'h2 && mReg <= 4'h8 &&
                fpdm_pkg::paramOk(8'(mReg - 4'h1), wrWord[15:0])) begin
              param_reg[wrMod][int'(mReg) - 1] <= wrWord[15:0];
            end
          end
        endcase
      end
      if (imgTake) begin
        param_reg[imgMod][int'(imgType)] <= imgValue;
      end
    end
  end

  // forwarded to the head-side engine; only applied images appear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      paramUpdValid <= 1'b0;
      paramUpdSlot  <= 4'h0;
      paramUpdType  <= 8'h00;
      paramUpdValue <= 16'h0000;
    end else begin
      paramUpdValid <= imgTake;
      if (imgTake) begin
        paramUpdSlot  <= outImgSlot;
        paramUpdType  <= imgType;
        paramUpdValue <= imgValue;
      end
    end
  end

  // sticky reject flags, set beats write-one-to-clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reject_reg <= '0;
    end else begin
      for (int m = 0; m < NUM_MOD; m++) begin
        if (outImgValid && run_reg && !imgIgnore && !imgAccept && imgMod == m) begin
          reject_reg[m] <= 1'b1;
        end else if (busWr && isGlobal && avs_address[4:2] == fpdm_pkg::REG_REJECT &&
                     wrWord[m]) begin
          reject_reg[m] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // input images and provider status
  // ----------------------------------------------------------------
  fpdm_image_mux #(
    .NUM_MOD (NUM_MOD)
  ) u_mux (
    .slot        (inRdSlot),
    .idx         (inRdIdx),
    .trigger     (triggerIn),
    .stationTemp (statTemp_reg),
    .objTemp     (objTemp_reg[3'(inRdSlot - 4'h1)]),
    .intTemp     (intTemp_reg[3'(inRdSlot - 4'h1)]),
    .byteData    (muxByte),
    .imgLen      (muxLen)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      inRdValid <= 1'b0;
      inRdData  <= 8'h00;
      inRdLen   <= 4'h0;
      inRdIops  <= fpdm_pkg::IOPS_BAD;
    end else begin
      inRdValid <= inRdReq;
      if (inRdReq) begin
        inRdData <= muxByte;
        inRdLen  <= muxLen;
        if (inRdSlot == 4'h0) begin
          inRdIops <= run_reg ? fpdm_pkg::IOPS_GOOD : fpdm_pkg::IOPS_BAD;
        end else if (int'(inRdSlot) <= NUM_MOD && run_reg &&
                     valid_reg[3'(inRdSlot - 4'h1)]) begin
          inRdIops <= fpdm_pkg::IOPS_GOOD;
        end else begin
          inRdIops <= fpdm_pkg::IOPS_BAD;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // diagnostics
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chanDiag       <= '0;
      commDiag       <= 8'h00;
      diagIrq        <= 1'b0;
      stationProblem <= 1'b0;
    end else begin
      chanDiag[0] <= diagEn_reg[0] && cfgFault_reg[0];
      for (int m = 0; m < NUM_MOD; m++) begin
        chanDiag[m+1] <= diagEn_reg[m+1] &&
                         (cfgFault_reg[m+1] || reject_reg[m] || commFault_reg[m]);
      end
      commDiag <= 8'h00;
      commDiag[fpdm_pkg::COMM_DIAG_BIT] <= |commFault_reg;
      diagIrq <= diagEn_reg[0] && (|commFault_reg) &&
                 !commDiag[fpdm_pkg::COMM_DIAG_BIT];
      stationProblem <= |(commFault_reg & diagEn_reg[NUM_MOD:1]);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_COMM_LEN: assert property (inRdReq && inRdSlot == 4'h0 |=> inRdLen == 4'h5)
    else $error("communicator image length not five");
  AST_TRIGGER: assert property (inRdReq && inRdSlot == 4'h0 && inRdIdx == 3'h0
    |=> inRdData == {7'h00, $past(triggerIn)})
    else $error("trigger bit wrong");
  AST_STAT_TEMP: assert property (inRdReq && inRdSlot == 4'h0 && inRdIdx == 3'h1
    |=> inRdData == $past(statTemp_reg[31:24]))
    else $error("station temperature not high byte first");
  AST_MOD_LEN: assert property (inRdReq && inRdSlot == 4'h1 |=> inRdLen == 4'h8)
    else $error("module image length not eight");
  AST_HEAD_TEMP: assert property (inRdReq && inRdSlot == 4'h1 && inRdIdx == 3'h4
    |=> inRdData == $past(intTemp_reg[0][31:24]))
    else $error("head temperature not at offset four");
  AST_IGNORE: assert property (outImgValid && outImgData[23:16] == 8'h00 |=> !paramUpdValid)
    else $error("type zero image applied");
  AST_BAD_TYPE: assert property (outImgValid && outImgData[23:16] > 8'h07 |=> !paramUpdValid)
    else $error("unknown type applied");
  AST_EMIS_RANGE: assert property (paramUpdValid && paramUpdType == 8'h01
    |-> paramUpdValue >= 16'h0064 && paramUpdValue <= 16'h044c)
    else $error("emissivity out of range applied");
  AST_RUN_ONLY: assert property (paramUpdValid |-> $past(run_reg))
    else $error("image applied outside data exchange");
  AST_IOPS: assert property (inRdReq && !run_reg |=> inRdIops == 8'h00)
    else $error("good status outside data exchange");
  AST_IRQ: assert property (diagIrq |-> commDiag[2] && $past(diagEn_reg[0]))
    else $error("interrupt without comm fault");
  AST_STATION: assert property (commFault_reg[0] && diagEn_reg[1] |=> stationProblem)
    else $error("station problem missing");
  AST_ONE_ACK: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low twice");

  COV_UPDATE: cover property (paramUpdValid && paramUpdType == 8'h01);
  COV_REJECT: cover property (outImgValid && run_reg && !imgIgnore && !imgAccept);
  COV_IRQ:    cover property (diagIrq);
  COV_GOOD:   cover property (inRdIops == 8'h80);
endmodule
`default_nettype wire

// File: tb/fpdm_plc_model.sv
// Purpose: controller model issuing output images and input reads
// Assumes: calls start just after a rising edge
// Notes:   type byte rests at zero between updates
`timescale 1ns/100ps
`default_nettype none
module fpdm_plc_model (
  input  wire logic        clk_sys,
  output logic             outImgValid,
  output logic      [3:0]  outImgSlot,
  output logic      [23:0] outImgData,
  output logic             inRdReq,
  output logic      [3:0]  inRdSlot,
  output logic      [2:0]  inRdIdx
);
  initial {outImgValid, outImgSlot, outImgData, inRdReq, inRdSlot, inRdIdx} = '0;
  task automatic putImg(input logic [23:0] d);
    outImgValid <= 1'b1;
    outImgSlot  <= 4'h1;
    outImgData  <= d;
    @(posedge clk_sys);
    outImgValid <= 1'b0;
    outImgData  <= 24'h00_0000;
  endtask
  task automatic getByte(input logic [3:0] s, input logic [2:0] i);
    inRdReq  <= 1'b1;
    inRdSlot <= s;
    inRdIdx  <= i;
    @(posedge clk_sys);
    inRdReq  <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb/tb_fieldbus_process_data_mapper.sv
// Purpose: self-checking bench for the process data mapper
// Assumes: module 0 sits at slot 1
// Notes:   bus tasks play the firmware
`timescale 1ns/100ps
`default_nettype none
module tb_fieldbus_process_data_mapper;
  logic        clk_sys = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic        triggerIn = 1'b1, avs_waitrequest, inRdReq, inRdValid, outImgValid;
  logic        paramUpdValid, diagIrq, stationProblem;
  logic [9:0]  avs_address = 10'h000;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
  logic [3:0]  avs_byteenable = 4'hf, inRdSlot, inRdLen, outImgSlot, paramUpdSlot;
  logic [2:0]  inRdIdx;
  logic [7:0]  inRdData, inRdIops, paramUpdType, commDiag;
  logic [23:0] outImgData;
  logic [15:0] paramUpdValue;
  logic [8:0]  chanDiag;
  logic [15:0] vals [1:7] = '{16'h0384, 16'h0002, 16'h1234, 16'h2706, 16'h0000, 16'h0001, 16'h00ff};
  int          mismatches = 0, comparisons = 0, cycles = 0, irqCnt = 0;
  fpdm_top dut_u (.*);
  fpdm_plc_model plc_u (.*);
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (diagIrq === 1'b1) irqCnt++;
    if (cycles == 3000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic test_done();
    if (mismatches == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // held until waitrequest is seen low; one idle edge keeps strobes apart
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    avs_write     <= w;
    avs_read      <= !w;
    avs_address   <= a;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic img(input logic [23:0] d, input logic e);
    plc_u.putImg(d);
    @(posedge clk_sys);
    chk("update", {31'h0, e}, {31'h0, paramUpdValid});
    if (e) begin
      chk("type", {24'h0, d[23:16]}, {24'h0, paramUpdType});
      chk("value", {16'h0, d[15:0]}, {16'h0, paramUpdValue});
      chk("slot", 1, {28'h0, paramUpdSlot});
    end
  endtask
  task automatic rdb(input logic [3:0] s, input logic [2:0] i, input logic [7:0] e, input logic [3:0] n);
    plc_u.getByte(s, i);
    @(posedge clk_sys);
    chk("valid", 1, inRdValid);
    chk("byte", e, inRdData);
    chk("length", n, inRdLen);
    chk("status", fpdm_pkg::IOPS_GOOD, inRdIops);
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    bus(0, 10'h108, 0);
    chk("emissivity", 32'h0000_03e8, rd);
    bus(0, 10'h3fc, 0);
    chk("unmapped", 0, rd);
    img(24'h01_0384, 1'b0);
    plc_u.getByte(4'h0, 3'h0);
    @(posedge clk_sys);
    chk("status", fpdm_pkg::IOPS_BAD, inRdIops);
    bus(1, 10'h000, 32'h0000_0001);
    bus(1, 10'h004, 32'h4120_0000);
    bus(1, 10'h100, 32'h1122_3344);
    bus(1, 10'h104, 32'h5566_7788);
    bus(1, 10'h00c, 32'h0000_0001);
    bus(0, 10'h020, 0);
    chk("alias", 0, rd);
    for (int i = 0; i < 5; i++) begin
      rdb(4'h0, i[2:0], 8'(40'h01_4120_0000 >> (32 - 8 * i)), 4'h5);
    end
    triggerIn <= 1'b0;
    rdb(4'h0, 3'h0, 8'h00, 4'h5);
    for (int i = 0; i < 8; i++) begin
      rdb(4'h1, i[2:0], 8'(64'h1122_3344_5566_7788 >> (56 - 8 * i)), 4'h8);
    end
    for (int t = 1; t < 8; t++) begin
      img({t[7:0], vals[t]}, 1'b1);
      bus(0, 10'h100 + 10'(4 * (t + 1)), 0);
      chk("setting", {16'h0000, vals[t]}, rd);
    end
    bus(1, 10'h124, 32'h0000_044c);
    bus(0, 10'h124, 0);
    chk("transmissivity", 32'h0000_03e8, rd);
    bus(1, 10'h124, 32'h0000_0064);
    bus(0, 10'h124, 0);
    chk("transmissivity", 32'h0000_0064, rd);
    bus(1, 10'h128, 32'h0000_0009);
    bus(1, 10'h128, 32'h0000_000f);
    bus(0, 10'h128, 0);
    chk("modes", 32'h0000_0009, rd);
    img(24'h00_0050, 1'b0);
    img(24'h01_044d, 1'b0);
    img(24'h08_0001, 1'b0);
    bus(0, 10'h108, 0);
    chk("emissivity", 32'h0000_0384, rd);
    chk("chanDiag", 0, chanDiag[1]);
    bus(1, 10'h008, 32'h0000_0003);
    bus(1, 10'h010, 32'h0000_0001);
    bus(1, 10'h014, 32'h0000_0001);
    repeat (2) @(posedge clk_sys);
    chk("chanDiag", 1, chanDiag[0]);
    chk("chanDiag", 1, chanDiag[1]);
    chk("commDiag", 1, commDiag[2]);
    chk("problem", 1, stationProblem);
    chk("irq count", 1, irqCnt);
    bus(0, 10'h018, 0);
    chk("reject", 1, rd);
    bus(1, 10'h018, 32'h0000_0001);
    bus(0, 10'h018, 0);
    chk("reject", 0, rd);
    test_done();
  end
endmodule
`default_nettype wire
